// file: olsr_pkg.sv
// olsr_pkg: constants for the link control, topology capture and channel mask registers
// assumes a 32-bit register port with byte offsets and one 50 MHz clock
package olsr_pkg;
    localparam logic [7:0]  OLSR_CTRL_SET      = 8'h50;
    localparam logic [7:0]  OLSR_CTRL_CLR      = 8'h54;
    localparam logic [7:0]  OLSR_TOPO_BASE     = 8'h64;
    localparam logic [7:0]  OLSR_TOPO_COUNT    = 8'h68;
    localparam logic [7:0]  OLSR_UPPER_SET     = 8'h70;
    localparam logic [7:0]  OLSR_UPPER_CLR     = 8'h74;
    localparam logic [7:0]  OLSR_LOWER_SET     = 8'h78;
    localparam logic [7:0]  OLSR_LOWER_CLR     = 8'h7C;
    localparam int          OLSR_BIT_DEFER     = 18;
    localparam int          OLSR_BIT_LINK      = 17;
    localparam int          OLSR_BIT_REINIT    = 16;
    localparam int          OLSR_FAULT_BIT     = 31;
    localparam int          OLSR_EPOCH_LSB     = 16;
    localparam int          OLSR_QCOUNT_LSB    = 2;
    localparam int          OLSR_BASE_LSB      = 11;
    localparam logic [7:0]  OLSR_EPOCH_MAX     = 8'hFF;
    localparam logic [8:0]  OLSR_QCOUNT_MAX    = 9'h1FF;
    localparam logic [20:0] OLSR_BASE_RST      = 21'h000000;
    localparam logic [31:0] OLSR_MASK_RST      = 32'h00000000;
    localparam logic [31:0] OLSR_CTRL_RSVD     = 32'h0000FFFF;
    localparam logic [31:0] OLSR_COUNT_RSVD    = 32'h7F00F803;
    localparam logic [31:0] OLSR_BASE_RSVD     = 32'h000007FF;
    // reinit sequence length in cycles
    localparam logic [3:0]  OLSR_REINIT_CYCLES = 4'h8;
    typedef enum logic [1:0] {OLSR_IDLE, OLSR_CAPTURE} olsr_cap_t;
endpackage

// file: olsr_mask.sv
// olsr_mask: one 32-bit set/clear channel mask
// assumes one-cycle strobes; set and clear never arrive together
`timescale 1ns/1ps
`default_nettype none
module olsr_mask
    import olsr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        flush,
    input  wire logic        set_stb,
    input  wire logic        clr_stb,
    input  wire logic [31:0] wdata,
    output logic      [31:0] mask_q
);
    logic [31:0] mask_d;

    always_comb begin
        mask_d = mask_q;
        if (set_stb) begin
            mask_d = mask_q | wdata;
        end else if (clr_stb) begin
            mask_d = mask_q & ~wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst || flush) begin
            mask_q <= OLSR_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end
endmodule // olsr_mask
`default_nettype wire

// file: olsr_regs.sv
// olsr_regs: control, topology capture and iso channel mask register bank
// assumes a synchronous register port and link-side event pulses on sys_clk
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module olsr_regs
    import olsr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata_q,
    input  wire logic        bus_reset_seen,
    input  wire logic        capture_start,
    input  wire logic        quadlet_written,
    input  wire logic        capture_done,
    input  wire logic        hw_error,
    input  wire logic        host_write_fail,
    input  wire logic        rx_pkt_valid,
    input  wire logic [5:0]  rx_channel,
    output logic             link_attached_q,
    output logic             rx_accept_q,
    output logic             tx_permit_q,
    output logic             deferred_write_gate_q,
    output logic             state_flush_q
);
    logic        link_q, link_d;
    logic        defer_d;
    logic [3:0]  reinit_cnt_q, reinit_cnt_d;
    logic        reinit_busy;
    logic [20:0] base_q, base_d;
    logic        fault_q, fault_d;
    logic        err_seen_q, err_seen_d;
    logic [7:0]  epoch_q, epoch_d;
    logic [8:0]  qcount_q, qcount_d;
    olsr_cap_t   cap_q, cap_d;
    logic [31:0] upper_mask, lower_mask;
    logic        flush;
    logic        wr_ctrl_set, wr_ctrl_clr;
    logic [31:0] ctrl_view, count_view, rdata_d;
    logic        accept_d, flush_d;

    assign reinit_busy = (reinit_cnt_q != 4'h0);
    assign flush       = reinit_busy;
    assign wr_ctrl_set = wr_stb && (addr == OLSR_CTRL_SET);
    assign wr_ctrl_clr = wr_stb && (addr == OLSR_CTRL_CLR);

    // control bits and reinit sequencer
    always_comb begin
        link_d       = link_q;
        defer_d      = deferred_write_gate_q;
        reinit_cnt_d = reinit_cnt_q;
        if (reinit_busy) begin
            reinit_cnt_d = reinit_cnt_q - 4'h1;
            link_d       = 1'b0;
            defer_d      = 1'b0;
        end else if (wr_ctrl_set) begin
            if (wdata[OLSR_BIT_REINIT]) begin
                reinit_cnt_d = OLSR_REINIT_CYCLES;
                link_d       = 1'b0;
                defer_d      = 1'b0;
            end else begin
                if (wdata[OLSR_BIT_LINK]) link_d = 1'b1;
                // software keeps this change to link-detached time
                if (wdata[OLSR_BIT_DEFER]) defer_d = 1'b1;
            end
        end else if (wr_ctrl_clr) begin
            if (wdata[OLSR_BIT_LINK]) link_d = 1'b0;
            if (wdata[OLSR_BIT_DEFER]) defer_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            link_q                <= 1'b0;
            deferred_write_gate_q <= 1'b0;
            reinit_cnt_q          <= 4'h0;
        end else begin
            link_q                <= link_d;
            deferred_write_gate_q <= defer_d;
            reinit_cnt_q          <= reinit_cnt_d;
        end
    end

    // topology capture status
    always_comb begin
        base_d     = base_q;
        fault_d    = fault_q;
        err_seen_d = err_seen_q;
        epoch_d    = epoch_q;
        qcount_d   = qcount_q;
        cap_d      = cap_q;
        if (wr_stb && addr == OLSR_TOPO_BASE) begin
            base_d = wdata[31:OLSR_BASE_LSB];
        end
        if (link_q) begin
            if (bus_reset_seen) begin
                epoch_d = (epoch_q == OLSR_EPOCH_MAX) ? 8'h00 : epoch_q + 8'h01;
            end
            case (cap_q)
                OLSR_IDLE: begin
                    if (capture_start) begin
                        qcount_d   = 9'h000;
                        err_seen_d = hw_error || host_write_fail;
                        cap_d      = OLSR_CAPTURE;
                    end
                end
                OLSR_CAPTURE: begin
                    if (quadlet_written && qcount_q != OLSR_QCOUNT_MAX) begin
                        qcount_d = qcount_q + 9'h001;
                    end
                    if (hw_error || host_write_fail) begin
                        err_seen_d = 1'b1;
                        fault_d    = 1'b1;
                    end
                    if (capture_done) begin
                        fault_d = err_seen_d;
                        cap_d   = OLSR_IDLE;
                    end
                end
                default: cap_d = OLSR_IDLE;
            endcase
        end else begin
            cap_d = OLSR_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst || flush) begin
            base_q     <= OLSR_BASE_RST;
            fault_q    <= 1'b0;
            err_seen_q <= 1'b0;
            epoch_q    <= 8'h00;
            qcount_q   <= 9'h000;
            cap_q      <= OLSR_IDLE;
        end else begin
            base_q     <= base_d;
            fault_q    <= fault_d;
            err_seen_q <= err_seen_d;
            epoch_q    <= epoch_d;
            qcount_q   <= qcount_d;
            cap_q      <= cap_d;
        end
    end

    olsr_mask u_upper (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .flush   (flush),
        .set_stb (wr_stb && addr == OLSR_UPPER_SET),
        .clr_stb (wr_stb && addr == OLSR_UPPER_CLR),
        .wdata   (wdata),
        .mask_q  (upper_mask)
    );

    olsr_mask u_lower (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .flush   (flush),
        .set_stb (wr_stb && addr == OLSR_LOWER_SET),
        .clr_stb (wr_stb && addr == OLSR_LOWER_CLR),
        .wdata   (wdata),
        .mask_q  (lower_mask)
    );

    // read mux and link-facing outputs
    always_comb begin
        ctrl_view  = 32'h00000000;
        ctrl_view[OLSR_BIT_DEFER]  = deferred_write_gate_q;
        ctrl_view[OLSR_BIT_LINK]   = link_q;
        ctrl_view[OLSR_BIT_REINIT] = reinit_busy;
        count_view = 32'h00000000;
        count_view[OLSR_FAULT_BIT] = fault_q;
        count_view[OLSR_EPOCH_LSB +: 8]  = epoch_q;
        count_view[OLSR_QCOUNT_LSB +: 9] = qcount_q;
        rdata_d = 32'h00000000;
        if (rd_stb) begin
            case (addr)
                OLSR_CTRL_SET, OLSR_CTRL_CLR: rdata_d = ctrl_view;
                OLSR_TOPO_BASE:  rdata_d = {base_q, 11'h000};
                OLSR_TOPO_COUNT: rdata_d = count_view;
                OLSR_UPPER_SET, OLSR_UPPER_CLR: rdata_d = upper_mask;
                OLSR_LOWER_SET, OLSR_LOWER_CLR: rdata_d = lower_mask;
                default: rdata_d = 32'h00000000;
            endcase
        end
        accept_d = 1'b0;
        if (link_q && link_d && rx_pkt_valid) begin
            accept_d = rx_channel[5] ? upper_mask[rx_channel[4:0]]
                                     : lower_mask[rx_channel[4:0]];
        end
        flush_d = (reinit_cnt_d != 4'h0);
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_q         <= 32'h00000000;
            link_attached_q <= 1'b0;
            rx_accept_q     <= 1'b0;
            tx_permit_q     <= 1'b0;
            state_flush_q   <= 1'b0;
        end else begin
            rdata_q         <= rdata_d;
            link_attached_q <= link_d;
            rx_accept_q     <= accept_d;
            tx_permit_q     <= link_d;
            state_flush_q   <= flush_d;
        end
    end

    // reinit sequence checks
    a_reinit_self_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_ctrl_set && wdata[OLSR_BIT_REINIT] && !reinit_busy
        |=> reinit_busy [*8] ##1 !reinit_busy)
        else $error("reinit length wrong");

    a_reinit_reads_one: assert property (@(posedge sys_clk) disable iff (!nrst)
        reinit_busy && rd_stb && addr == OLSR_CTRL_SET
        |=> rdata_q[OLSR_BIT_REINIT])
        else $error("reinit bit not shown");

    a_link_reinit_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        reinit_busy
        |=> !link_q && !deferred_write_gate_q)
        else $error("control bits survived reinit");

    a_reinit_masks_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        reinit_busy
        |=> upper_mask == OLSR_MASK_RST && lower_mask == OLSR_MASK_RST)
        else $error("masks survived reinit");

    a_reinit_base_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        reinit_busy
        |=> base_q == OLSR_BASE_RST)
        else $error("base survived reinit");

    a_reinit_count_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        reinit_busy
        |=> epoch_q == 8'h00 && qcount_q == 9'h000 && !fault_q)
        else $error("count survived reinit");

    // detached link checks
    a_detached_no_rx: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_q
        |=> !rx_accept_q)
        else $error("rx while detached");

    a_detached_no_tx: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_q && !wr_ctrl_set
        |=> !tx_permit_q && !link_attached_q)
        else $error("tx while detached");

    a_detached_no_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_q
        |=> cap_q == OLSR_IDLE)
        else $error("capture while detached");

    a_detached_epoch_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_q && !flush
        |=> epoch_q == $past(epoch_q))
        else $error("epoch moved while detached");

    // topology capture checks
    a_epoch_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && bus_reset_seen && !flush
        |=> epoch_q == 8'($past(epoch_q) + 8'h01))
        else $error("epoch step wrong");

    a_epoch_rollover: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && bus_reset_seen && !flush && epoch_q == OLSR_EPOCH_MAX
        |=> epoch_q == 8'h00)
        else $error("epoch did not wrap");

    a_qcount_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && !flush && cap_q == OLSR_IDLE && capture_start
        |=> qcount_q == 9'h000)
        else $error("quadlet count not cleared");

    a_qcount_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && !flush && cap_q == OLSR_CAPTURE && quadlet_written && qcount_q != OLSR_QCOUNT_MAX
        |=> qcount_q == 9'($past(qcount_q) + 9'h001))
        else $error("quadlet count step wrong");

    a_fault_on_error: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && !flush && cap_q == OLSR_CAPTURE && (hw_error || host_write_fail)
        |=> fault_q)
        else $error("fault not set");

    a_fault_kept_done: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && !flush && cap_q == OLSR_CAPTURE && capture_done && err_seen_q
        |=> fault_q)
        else $error("fault lost at capture end");

    a_fault_clean_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && !flush && cap_q == OLSR_CAPTURE && capture_done && !err_seen_q
        && !hw_error && !host_write_fail |=> !fault_q)
        else $error("fault not cleared");

    // register read and write checks
    a_count_reserved: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_stb && addr == OLSR_TOPO_COUNT
        |=> (rdata_q & OLSR_COUNT_RSVD) == 32'h00000000)
        else $error("count reserved bits set");

    a_ctrl_reserved: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_stb && (addr == OLSR_CTRL_SET || addr == OLSR_CTRL_CLR)
        |=> (rdata_q & OLSR_CTRL_RSVD) == 32'h00000000)
        else $error("control low bits set");

    a_base_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_stb && addr == OLSR_TOPO_BASE && !flush
        |=> base_q == $past(wdata[31:OLSR_BASE_LSB]))
        else $error("base not written");

    a_base_aligned: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_stb && addr == OLSR_TOPO_BASE
        |=> (rdata_q & OLSR_BASE_RSVD) == 32'h00000000)
        else $error("base not aligned");

    a_mask_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_stb && addr == OLSR_UPPER_CLR
        |=> rdata_q == $past(upper_mask))
        else $error("upper mask readback");

    // channel mask checks
    a_upper_accept: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && rx_pkt_valid && rx_channel[5] && !wr_ctrl_set && !wr_ctrl_clr
        |=> rx_accept_q == $past(upper_mask[rx_channel[4:0]]))
        else $error("upper channel accept wrong");

    a_lower_accept: assert property (@(posedge sys_clk) disable iff (!nrst)
        link_q && rx_pkt_valid && !rx_channel[5] && !wr_ctrl_set && !wr_ctrl_clr
        |=> rx_accept_q == $past(lower_mask[rx_channel[4:0]]))
        else $error("lower channel accept wrong");

    a_set_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_stb && addr == OLSR_UPPER_SET && !flush
        |=> (upper_mask & $past(wdata)) == $past(wdata))
        else $error("set write missed bits");

    a_clear_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_stb && addr == OLSR_UPPER_CLR && !flush
        |=> (upper_mask & $past(wdata)) == 32'h00000000)
        else $error("clear write missed bits");

    a_zero_write_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_stb && addr == OLSR_LOWER_CLR && wdata == 32'h00000000 && !flush
        |=> lower_mask == $past(lower_mask))
        else $error("zero write changed mask");
endmodule // olsr_regs
`default_nettype wire

// file: olsr_link_model.sv
// olsr_link_model: far-side link events (bus resets, self-id captures, iso packets)
// assumes the bench calls its tasks; every pulse lasts one sys_clk cycle except quadlet_written, held for nq cycles
`timescale 1ns/1ps
`default_nettype none
module olsr_link_model (
    input  wire logic       sys_clk,
    output logic            bus_reset_seen,
    output logic            capture_start,
    output logic            quadlet_written,
    output logic            capture_done,
    output logic            hw_error,
    output logic            host_write_fail,
    output logic            rx_pkt_valid,
    output logic      [5:0] rx_channel
);
    initial begin
        {bus_reset_seen, capture_start, quadlet_written, capture_done} = 4'h0;
        {hw_error, host_write_fail, rx_pkt_valid} = 3'h0;
        rx_channel = 6'h00;
    end
    task automatic bus_resets(input int n);
        repeat (n) begin
            @(posedge sys_clk) bus_reset_seen <= 1'b1;
            @(posedge sys_clk) bus_reset_seen <= 1'b0;
        end
    endtask
    // err: 0 clean, 1 internal fault, 2 failed host write
    task automatic capture(input int nq, input int err);
        @(posedge sys_clk) capture_start <= 1'b1;
        @(posedge sys_clk) capture_start <= 1'b0;
        if (nq > 0) begin
            quadlet_written <= 1'b1;
            repeat (nq) @(posedge sys_clk);
            quadlet_written <= 1'b0;
        end
        hw_error        <= (err == 1);
        host_write_fail <= (err == 2);
        @(posedge sys_clk) {hw_error, host_write_fail} <= 2'h0;
        capture_done <= 1'b1;
        @(posedge sys_clk) capture_done <= 1'b0;
    endtask
    // channel lines toggle once the header is gone
    task automatic packet(input logic [5:0] ch);
        @(posedge sys_clk) rx_pkt_valid <= 1'b1;
        rx_channel <= ch;
        @(posedge sys_clk) rx_pkt_valid <= 1'b0;
        rx_channel <= ~ch;
    endtask
endmodule // olsr_link_model
`default_nettype wire

// file: test_ohci_link_selfid_regs.sv
// test_ohci_link_selfid_regs: self-checking bench for olsr_regs
// assumes olsr_pkg and olsr_link_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ohci_link_selfid_regs;
    import olsr_pkg::*;
    logic        sys_clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata_q, rd;
    logic        brs, cst, qw, cdn, hwe, hwf, rxv;
    logic [5:0]  rxc;
    logic        attached, accept, permit, defer, flush;
    int          n_fail = 0, total_checks = 0, cyc = 0;
    olsr_regs u_dut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .bus_reset_seen(brs),
        .capture_start(cst), .quadlet_written(qw), .capture_done(cdn), .hw_error(hwe),
        .host_write_fail(hwf), .rx_pkt_valid(rxv), .rx_channel(rxc),
        .link_attached_q(attached), .rx_accept_q(accept), .tx_permit_q(permit),
        .deferred_write_gate_q(defer), .state_flush_q(flush));
    olsr_link_model u_link (.sys_clk(sys_clk), .bus_reset_seen(brs), .capture_start(cst),
        .quadlet_written(qw), .capture_done(cdn), .hw_error(hwe),
        .host_write_fail(hwf), .rx_pkt_valid(rxv), .rx_channel(rxc));
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) {wr_stb, addr, wdata} <= {1'b1, a, d};
        @(posedge sys_clk) wr_stb <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk) {rd_stb, addr} <= {1'b1, a};
        @(posedge sys_clk) rd_stb <= 1'b0;
        #1 rd = rdata_q;
        chk($sformatf("reg %h", a), rd, exp);
    endtask
    task automatic pkt(input logic [5:0] ch, input logic exp);
        u_link.packet(ch);
        #1 chk($sformatf("accept ch %0d", ch), {31'h0, accept}, {31'h0, exp});
    endtask
    task automatic t_reset;
        rdchk(OLSR_CTRL_SET, 32'h00000000);
        rdchk(OLSR_TOPO_COUNT, 32'h00000000);
        rdchk(OLSR_UPPER_SET, OLSR_MASK_RST);
        rdchk(OLSR_LOWER_CLR, OLSR_MASK_RST);
        $display("test reset values done");
    endtask
    task automatic t_link;
        wr(OLSR_CTRL_SET, 32'h0004FFFF);
        wr(OLSR_CTRL_SET, 32'h00020000);
        #1 chk("permit", {30'h0, permit, attached}, 32'h00000003);
        rdchk(OLSR_CTRL_CLR, 32'h00060000);
        chk("defer", {31'h0, defer}, 32'h00000001);
        $display("test link gate done");
    endtask
    task automatic t_masks;
        wr(OLSR_UPPER_SET, 32'h00000002);
        wr(OLSR_LOWER_SET, 32'h00000020);
        pkt(6'd33, 1'b1);
        pkt(6'd32, 1'b0);
        pkt(6'd5, 1'b1);
        rdchk(OLSR_UPPER_SET, 32'h00000002);
        rdchk(OLSR_UPPER_CLR, 32'h00000002);
        wr(OLSR_UPPER_CLR, 32'h00000002);
        wr(OLSR_LOWER_CLR, 32'h00000000);
        pkt(6'd33, 1'b0);
        rdchk(OLSR_LOWER_SET, 32'h00000020);
        wr(OLSR_CTRL_CLR, 32'h00020000);
        pkt(6'd5, 1'b0);
        chk("permit off", {31'h0, permit}, 32'h00000000);
        $display("test channel masks done");
    endtask
    task automatic t_capture;
        u_link.bus_resets(1);
        rdchk(OLSR_TOPO_COUNT, 32'h00000000);
        wr(OLSR_CTRL_SET, 32'h00020000);
        u_link.bus_resets(1);
        u_link.capture(3, 0);
        rdchk(OLSR_TOPO_COUNT, 32'h0001000C);
        u_link.capture(2, 1);
        rdchk(OLSR_TOPO_COUNT, 32'h80010008);
        u_link.capture(0, 0);
        rdchk(OLSR_TOPO_COUNT, 32'h00010000);
        u_link.capture(1, 2);
        rdchk(OLSR_TOPO_COUNT, 32'h80010004);
        u_link.bus_resets(255);
        rdchk(OLSR_TOPO_COUNT, 32'h80000004);
        $display("test topology capture done");
    endtask
    task automatic t_base;
        wr(OLSR_TOPO_BASE, 32'hFFFFFFFF);
        rdchk(OLSR_TOPO_BASE, 32'hFFFFF800);
        wr(OLSR_TOPO_COUNT, 32'hFFFFFFFF);
        rdchk(OLSR_TOPO_COUNT, 32'h80000004);
        rdchk(8'h44, 32'h00000000);
        $display("test buffer base done");
    endtask
    task automatic t_reinit;
        wr(OLSR_UPPER_SET, 32'h80000001);
        wr(OLSR_CTRL_SET, 32'h00010000);
        rdchk(OLSR_CTRL_SET, 32'h00010000);
        chk("flush", {31'h0, flush}, 32'h00000001);
        repeat (10) @(posedge sys_clk);
        rdchk(OLSR_CTRL_SET, 32'h00000000);
        chk("gate", {29'h0, attached, permit, defer}, 32'h00000000);
        rdchk(OLSR_UPPER_CLR, OLSR_MASK_RST);
        rdchk(OLSR_TOPO_BASE, 32'h00000000);
        rdchk(OLSR_TOPO_COUNT, 32'h00000000);
        $display("test controller reinit done");
    endtask
    task automatic t_hw_reset;
        wr(OLSR_CTRL_SET, 32'h00060000);
        #1 chk("attached", {31'h0, attached}, 32'h00000001);
        @(posedge sys_clk) nrst <= 1'b0;
        @(posedge sys_clk) nrst <= 1'b1;
        rdchk(OLSR_CTRL_SET, 32'h00000000);
        chk("gate after reset", {30'h0, attached, permit}, 32'h00000000);
        $display("test hardware reset done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_link();
        t_masks();
        t_capture();
        t_base();
        t_reinit();
        t_hw_reset();
        wrap_up();
    end
endmodule // test_ohci_link_selfid_regs
`default_nettype wire
